// *** hdl/apc_pkg.sv ***
package apc_pkg;
   localparam logic [7:0] OPT_IDX = 8'h06;
   localparam logic [7:0] SMA_IDX = 8'h07;
   localparam logic [7:0] NSB_IDX = 8'h08;
   localparam logic [31:0] OPT_RST = 32'h0000_0000;
   localparam logic [31:0] SMA_RST = 32'h0000_0000;
   localparam logic [31:0] NSB_RST = 32'h0000_0000;
   localparam logic [31:0] OPT_WMASK = 32'h0F7D_FFFF;
   localparam logic [31:0] SMA_WMASK = 32'hFFFF_FFFF;
   localparam logic [31:0] NSB_WMASK = 32'h00FF_FFFF;
   localparam int RD_BIT = 27;
   localparam int AXIS_SEL_BIT = 26;
   localparam int COEFF_SKIP_BIT = 25;
   localparam int SS_BIT = 24;
   localparam int INVERT_BIT = 22;
   localparam int POST_FLIP_BIT = 21;
   localparam int SEG_EN_BIT = 20;
   localparam int HARM_EN_BIT = 19;
   localparam int PRE_FLIP_BIT = 18;
   localparam int SMOOTH_EN_BIT = 16;
   localparam int OPT_FIELD_LSB = 16;
   localparam int ORIGIN_INIT_LSB = 4;
   localparam int WINDOW_INIT_LSB = 20;
   localparam int SHIFT_INIT_LSB = 16;
   localparam int UPPER_LSB = 16;
   localparam logic [15:0] HALF_TURN = 16'h8000;
   localparam int SEG_AXIS_LSB = 12;
   localparam int COEFF_FRAC = 14;
   localparam int GAIN_FRAC = 8;
   localparam int WINDOW_UNIT_SHIFT = 1;

   function automatic logic signed [16:0] apc_sm_to_signed(input logic [15:0] c);
      logic signed [16:0] mag;
      mag = signed'({2'b00, c[14:0]});
      return c[15] ? -mag : mag;
   endfunction

   function automatic logic [15:0] apc_neg(input logic [15:0] a);
      return 16'h0000 - a;
   endfunction
endpackage

// *** hdl/apc_fifo.sv ***
`timescale 1ns/100ps
module apc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] rd;
      logic [PW-1:0] wr;
      logic [CW-1:0] cnt;
   } apc_fifo_s;
   apc_fifo_s st_r;
   apc_fifo_s st_nxt;
   logic push;
   logic pop;

   assign in_ready = st_r.cnt != CW'(DEPTH);
   assign out_valid = st_r.cnt != '0;
   assign out_data = st_r.mem[st_r.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr] = in_data;
         st_nxt.wr = (st_r.wr == PW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd = (st_r.rd == PW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // apc_fifo

// *** hdl/apc_smooth.sv ***
`timescale 1ns/100ps
module apc_smooth (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic enable,
   input wire logic [15:0] x,
   input wire logic [15:0] num_a,
   input wire logic [15:0] num_b,
   input wire logic [15:0] den_a,
   input wire logic [7:0] num_shift,
   input wire logic [15:0] window,
   output logic [15:0] y,
   output logic flush
);
   typedef struct packed {
      logic [15:0] y;
      logic signed [16:0] e_prev;
      logic signed [16:0] dy_prev;
   } apc_smooth_s;
   apc_smooth_s st_r;
   apc_smooth_s st_nxt;
   logic [15:0] diff;
   logic signed [16:0] e;
   logic [16:0] mag;
   logic signed [39:0] acc_num;
   logic signed [39:0] acc_den;
   logic signed [39:0] dy;

   always_comb begin
      // The error is taken around the circle so a 0/360 crossing is a small step.
      diff = x - st_r.y;
      e = signed'({diff[15], diff});
      mag = diff[15] ? 17'h10000 - {1'b0, diff} : {1'b0, diff};
      flush = enable && (window != 16'h0000)
         && (mag > ({1'b0, window} << apc_pkg::WINDOW_UNIT_SHIFT));
      // Operands are widened first, so a full-scale product cannot wrap.
      acc_num = 40'(apc_pkg::apc_sm_to_signed(num_a)) * 40'(e)
         + 40'(apc_pkg::apc_sm_to_signed(num_b)) * 40'(st_r.e_prev);
      acc_num = acc_num >>> apc_pkg::COEFF_FRAC;
      acc_num = acc_num >>> num_shift;
      acc_den = 40'(apc_pkg::apc_sm_to_signed(den_a)) * 40'(st_r.dy_prev);
      acc_den = acc_den >>> apc_pkg::COEFF_FRAC;
      dy = acc_num - acc_den;
      y = (enable && !flush) ? st_r.y + dy[15:0] : x;
      st_nxt = st_r;
      if (step) begin
         st_nxt.y = y;
         st_nxt.e_prev = (enable && !flush) ? e : '0;
         st_nxt.dy_prev = (enable && !flush) ? signed'({dy[15], dy[15:0]}) : '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // apc_smooth

// *** hdl/apc_top.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Die-rotation bit adds half turn last.
// - Axis bit picks encoder or internal segment index.
// - Skip bit applies bias only, no terms.
// - Short-stroke bit enables checks, clamps and gain.
// - Invert bit outputs upper limit minus angle.
// - Post-direction bit flips angle after linearization.
// - Pre-direction bit flips angle before linearization.
// - Segment enable bit turns segment linearization on.
// - Harmonic enable bit turns harmonic correction on.
// - Smoothing bit enables input filter, default off.
// - Origin shift is subtracted after linearization.
// - Init loads origin into 15:4, clears 3:0.
// - Error beyond nonzero window flushes the filter.
// - Init loads window into 23:20, clears rest.
// - Coefficients are sign-magnitude with 14 fraction bits.
// - Numerator shift scales numerators, never denominators.
// - Init loads shift into 20:16, clears 23:21.
module apc_top #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic init_load,
   input wire logic [11:0] stored_origin_shift,
   input wire logic [3:0] stored_reset_window,
   input wire logic [4:0] stored_numerator_shift,
   input wire logic [11:0] stored_option_bits,
   input wire logic [15:0] stored_numerator_a,
   input wire logic [15:0] stored_numerator_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [15:0] in_angle,
   input wire logic [15:0] encoder_angle,
   input wire logic [15:0] smoothing_denominator_a,
   output logic [3:0] segment_index,
   input wire logic [15:0] segment_table_terms,
   input wire logic [15:0] segment_table_bias,
   input wire logic [15:0] harmonic_correction,
   input wire logic [15:0] upper_limit_value,
   input wire logic [15:0] lower_limit_value,
   input wire logic [15:0] angle_floor_check,
   input wire logic [15:0] angle_ceiling_check,
   input wire logic [15:0] gain,
   output logic out_valid,
   input wire logic out_ready,
   output logic [15:0] out_angle,
   output logic floor_hit,
   output logic ceiling_hit,
   output logic filter_flushed
);
   typedef struct packed {
      logic [31:0] opt;
      logic [31:0] sma;
      logic [31:0] nsb;
      logic [31:0] rdata;
      logic floor_hit;
      logic ceiling_hit;
      logic flushed;
   } apc_state_s;
   apc_state_s st_r;
   apc_state_s st_nxt;
   logic fifo_in_ready;
   logic accept;
   logic flush;
   logic [15:0] filt_y;
   logic [15:0] pre_a;
   logic [15:0] seg_axis;
   logic [15:0] seg_a;
   logic [15:0] lin_a;
   logic [15:0] post_a;
   logic [15:0] zo_a;
   logic [31:0] gprod;
   logic [15:0] gained;
   logic [15:0] clamped;
   logic [15:0] ss_a;
   logic [15:0] inv_a;
   logic [15:0] fin_a;
   logic floor_c;
   logic ceil_c;

   assign accept = in_valid && fifo_in_ready;
   assign in_ready = fifo_in_ready;
   assign reg_rdata = st_r.rdata;
   assign floor_hit = st_r.floor_hit;
   assign ceiling_hit = st_r.ceiling_hit;
   assign filter_flushed = st_r.flushed;

   apc_smooth u_smooth (
      .clk(clk),
      .rst_n(rst_n),
      .step(accept),
      .enable(st_r.opt[apc_pkg::SMOOTH_EN_BIT]),
      .x(in_angle),
      .num_a(st_r.sma[15:0]),
      .num_b(st_r.nsb[15:0]),
      .den_a(smoothing_denominator_a),
      .num_shift(st_r.nsb[23:16]),
      .window(st_r.sma[31:16]),
      .y(filt_y),
      .flush(flush)
   );

   // The stages are chained in one cycle; all sums wrap at one turn.
   always_comb begin
      pre_a = st_r.opt[apc_pkg::PRE_FLIP_BIT]
         ? apc_pkg::apc_neg(filt_y) : filt_y;
      seg_axis = st_r.opt[apc_pkg::AXIS_SEL_BIT] ? in_angle : encoder_angle;
      segment_index = seg_axis[apc_pkg::SEG_AXIS_LSB +: 4];
      seg_a = pre_a;
      if (st_r.opt[apc_pkg::SEG_EN_BIT]) begin
         seg_a = pre_a + segment_table_bias
            + (st_r.opt[apc_pkg::COEFF_SKIP_BIT]
            ? 16'h0000 : segment_table_terms);
      end
      lin_a = st_r.opt[apc_pkg::HARM_EN_BIT] ? seg_a + harmonic_correction : seg_a;
      post_a = st_r.opt[apc_pkg::POST_FLIP_BIT] ? apc_pkg::apc_neg(lin_a) : lin_a;
      zo_a = post_a - st_r.opt[15:0];
      gprod = 32'(zo_a) * 32'(gain);
      gained = zo_a + gprod[apc_pkg::GAIN_FRAC +: 16];
      floor_c = st_r.opt[apc_pkg::SS_BIT] && (gained < angle_floor_check);
      ceil_c = st_r.opt[apc_pkg::SS_BIT] && (gained > angle_ceiling_check);
      if (gained > upper_limit_value) begin
         clamped = upper_limit_value;
      end else if (gained < lower_limit_value) begin
         clamped = lower_limit_value;
      end else begin
         clamped = gained;
      end
      ss_a = st_r.opt[apc_pkg::SS_BIT] ? clamped : zo_a;
      inv_a = st_r.opt[apc_pkg::INVERT_BIT] ? upper_limit_value - ss_a : ss_a;
      fin_a = st_r.opt[apc_pkg::RD_BIT] ? inv_a + apc_pkg::HALF_TURN : inv_a;
   end

   // An init load takes priority over a host write in the same cycle.
   always_comb begin
      st_nxt = st_r;
      st_nxt.floor_hit = accept && floor_c;
      st_nxt.ceiling_hit = accept && ceil_c;
      st_nxt.flushed = accept && flush;
      if (init_load) begin
         st_nxt.opt = {4'h0, stored_option_bits, stored_origin_shift, 4'h0}
            & apc_pkg::OPT_WMASK;
         st_nxt.sma = {8'h00, stored_reset_window, 4'h0, stored_numerator_a};
         st_nxt.nsb = {8'h00, 3'b000, stored_numerator_shift, stored_numerator_b};
      end else if (reg_wr) begin
         case (reg_addr)
            apc_pkg::OPT_IDX: begin
               st_nxt.opt = reg_wdata & apc_pkg::OPT_WMASK;
            end
            apc_pkg::SMA_IDX: begin
               st_nxt.sma = reg_wdata & apc_pkg::SMA_WMASK;
            end
            apc_pkg::NSB_IDX: begin
               st_nxt.nsb = reg_wdata & apc_pkg::NSB_WMASK;
            end
            default: begin
               st_nxt.opt = st_r.opt;
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            apc_pkg::OPT_IDX: begin
               st_nxt.rdata = st_r.opt;
            end
            apc_pkg::SMA_IDX: begin
               st_nxt.rdata = st_r.sma;
            end
            apc_pkg::NSB_IDX: begin
               st_nxt.rdata = st_r.nsb;
            end
            default: begin
               st_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.opt <= apc_pkg::OPT_RST;
         st_r.sma <= apc_pkg::SMA_RST;
         st_r.nsb <= apc_pkg::NSB_RST;
         st_r.rdata <= 32'h0000_0000;
         st_r.floor_hit <= 1'b0;
         st_r.ceiling_hit <= 1'b0;
         st_r.flushed <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // A small output queue lets the consumer stall without losing samples.
   apc_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fin_a),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_angle)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Stage checks other than die_rotate_a and stroke_clamp_a hold in every cycle, since the chain is combinational.
   init_origin_a: assert property (
      init_load |=> st_r.opt[15:0] == {$past(stored_origin_shift), 4'h0})
      else $error("origin init wrong");
   init_window_a: assert property (
      init_load |=> st_r.sma[31:16] == {8'h00, $past(stored_reset_window), 4'h0})
      else $error("window init wrong");
   init_shift_a: assert property (
      init_load |=> st_r.nsb[23:16] == {3'b000, $past(stored_numerator_shift)})
      else $error("shift init wrong");
   die_rotate_a: assert property (
      accept && st_r.opt[apc_pkg::RD_BIT] |-> fin_a == inv_a + apc_pkg::HALF_TURN)
      else $error("die rotation wrong");
   seg_axis_a: assert property (
      segment_index == (st_r.opt[apc_pkg::AXIS_SEL_BIT]
      ? in_angle[15:12] : encoder_angle[15:12]))
      else $error("segment axis wrong");
   seg_skip_a: assert property (
      st_r.opt[apc_pkg::SEG_EN_BIT] && st_r.opt[apc_pkg::COEFF_SKIP_BIT]
      |-> seg_a == pre_a + segment_table_bias)
      else $error("skip wrong");
   invert_out_a: assert property (
      st_r.opt[apc_pkg::INVERT_BIT] && !st_r.opt[apc_pkg::RD_BIT]
      |-> fin_a == upper_limit_value - ss_a)
      else $error("invert wrong");
   stroke_clamp_a: assert property (
      accept && st_r.opt[apc_pkg::SS_BIT] && !st_r.opt[apc_pkg::INVERT_BIT]
      && !st_r.opt[apc_pkg::RD_BIT]
      |-> fin_a <= upper_limit_value || lower_limit_value > upper_limit_value)
      else $error("clamp wrong");
   origin_sub_a: assert property (
      !st_r.opt[apc_pkg::SS_BIT] && !st_r.opt[apc_pkg::INVERT_BIT]
      && !st_r.opt[apc_pkg::RD_BIT] |-> fin_a + st_r.opt[15:0] == post_a)
      else $error("origin wrong");
   floor_flag_a: assert property (
      accept && floor_c |=> floor_hit ##1 !floor_hit || $past(accept && floor_c, 1))
      else $error("floor flag wrong");
   opt_write_a: assert property (
      reg_wr && !init_load && reg_addr == apc_pkg::OPT_IDX
      |=> st_r.opt == ($past(reg_wdata) & apc_pkg::OPT_WMASK))
      else $error("option write lost");
   pass_thru_a: assert property (
      st_r.opt[27:16] == 12'h000 && st_r.opt[15:0] == 16'h0000 |-> fin_a == in_angle)
      else $error("bypass wrong");
   ceil_flag_a: assert property (
      accept && ceil_c |=> ceiling_hit)
      else $error("ceiling flag wrong");
   flush_flag_a: assert property (
      accept && flush |=> filter_flushed)
      else $error("flush flag wrong");
   stroke_off_a: assert property (
      !st_r.opt[apc_pkg::SS_BIT] |-> !floor_c && !ceil_c && ss_a == zo_a)
      else $error("short stroke not bypassed");
   pre_flip_a: assert property (
      st_r.opt[apc_pkg::PRE_FLIP_BIT] |-> pre_a + filt_y == 16'h0000)
      else $error("pre direction wrong");
   post_flip_a: assert property (
      st_r.opt[apc_pkg::POST_FLIP_BIT] |-> post_a + lin_a == 16'h0000)
      else $error("post direction wrong");
   seg_off_a: assert property (
      !st_r.opt[apc_pkg::SEG_EN_BIT] |-> seg_a == pre_a)
      else $error("segment stage not bypassed");
   harm_off_a: assert property (
      !st_r.opt[apc_pkg::HARM_EN_BIT] |-> lin_a == seg_a)
      else $error("harmonic stage not bypassed");
   rotate_off_a: assert property (
      !st_r.opt[apc_pkg::RD_BIT] |-> fin_a == inv_a)
      else $error("rotation not bypassed");
   smooth_off_a: assert property (
      !st_r.opt[apc_pkg::SMOOTH_EN_BIT] |-> filt_y == in_angle)
      else $error("filter not bypassed");
   window_off_a: assert property (
      st_r.sma[31:16] == 16'h0000 |-> !flush)
      else $error("flush with window off");
   rsvd_zero_a: assert property (
      st_r.opt[31:28] == 4'h0 && !st_r.opt[23] && !st_r.opt[17])
      else $error("reserved option bit set");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   sma_write_a: assert property (
      reg_wr && !init_load && reg_addr == apc_pkg::SMA_IDX
      |=> st_r.sma == $past(reg_wdata))
      else $error("window write lost");

   filt_on_c: cover property (accept && st_r.opt[apc_pkg::SMOOTH_EN_BIT]);
   flush_c: cover property (accept && flush);
   fifo_full_c: cover property (in_valid && !fifo_in_ready);
   floor_c_c: cover property (accept && floor_c);
   ceil_c_c: cover property (accept && ceil_c);
endmodule // apc_top

// *** tb/apc_host.sv ***
`timescale 1ns/100ps
// Host controller on the register port. It drives only on falling edges and
// scrambles the write data once a write is done, so no stale word looks valid.
module apc_host (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0000_0000;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
endmodule // apc_host

// *** tb/apc_top_tb.sv ***
`timescale 1ns/100ps
module apc_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, init_load = 1'b0, fl, fh, ch;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [11:0] stored_origin_shift = 12'h000, stored_option_bits = 12'h000;
   logic [3:0] stored_reset_window = 4'h0, segment_index;
   logic [4:0] stored_numerator_shift = 5'h00;
   logic [15:0] stored_numerator_a = 16'h0000, stored_numerator_b = 16'h0000;
   logic in_valid = 1'b0, in_ready, out_valid, out_ready = 1'b0;
   logic floor_hit, ceiling_hit, filter_flushed;
   logic [15:0] in_angle = 16'h0000, out_angle, encoder_angle = 16'hA5A5;
   logic [15:0] smoothing_denominator_a = 16'h0000, segment_table_terms = 16'h0111;
   logic [15:0] segment_table_bias = 16'h0022, harmonic_correction = 16'h0300;
   logic [15:0] upper_limit_value = 16'h3000, lower_limit_value = 16'h0100;
   logic [15:0] angle_floor_check = 16'h0000, angle_ceiling_check = 16'hFFFF;
   logic [15:0] gain = 16'h0080;
   logic [31:0] modes [10] = '{32'h0000_0123, 32'h0800_0123, 32'h0210_0123,
      32'h0100_0123, 32'h0040_0123, 32'h0020_0123, 32'h0010_0123,
      32'h0008_0123, 32'h0004_0123, 32'h0F7C_0123};
   int fail_count = 0, n_checks = 0;

   always #5 clk = ~clk;

   apc_host apc_host_i (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

   apc_top #(.FIFO_DEPTH(4)) apc_top_i (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .init_load, .stored_origin_shift, .stored_reset_window,
      .stored_numerator_shift, .stored_option_bits, .stored_numerator_a,
      .stored_numerator_b, .in_valid, .in_ready, .in_angle, .encoder_angle,
      .smoothing_denominator_a, .segment_index, .segment_table_terms,
      .segment_table_bias, .harmonic_correction, .upper_limit_value,
      .lower_limit_value, .angle_floor_check, .angle_ceiling_check, .gain,
      .out_valid, .out_ready, .out_angle, .floor_hit, .ceiling_hit, .filter_flushed);

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apc_host_i.rd(a, d);
      chk(d, exp);
   endtask

   // Offer one sample; fl, fh and ch keep the flush, floor and ceiling flags
   // of the cycle after acceptance.
   task automatic send(input logic [15:0] x);
      int i;
      @(negedge clk);
      in_valid = 1'b1;
      in_angle = x;
      for (i = 0; i < 50 && in_ready !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin
         fail_count++;
         conclude();
      end
      @(negedge clk);
      in_valid = 1'b0;
      in_angle = ~x;
      fl = filter_flushed;
      fh = floor_hit;
      ch = ceiling_hit;
   endtask

   task automatic take(input logic [15:0] exp);
      int i;
      for (i = 0; i < 50 && out_valid !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin
         fail_count++;
         conclude();
      end
      chk(out_angle, exp);
      out_ready = 1'b1;
      @(negedge clk);
      out_ready = 1'b0;
   endtask

   // Reference chain, stage by stage, all sums wrapping per turn.
   function automatic logic [15:0] mdl(input logic [31:0] o, input logic [15:0] x);
      logic [15:0] a;
      a = x;
      if (o[18]) a = 16'h0000 - a;
      if (o[20]) a = a + segment_table_bias + (o[25] ? 16'h0000 : segment_table_terms);
      if (o[19]) a = a + harmonic_correction;
      if (o[21]) a = 16'h0000 - a;
      a = a - o[15:0];
      if (o[24]) begin
         a = a + 16'((32'(a) * 32'(gain)) >> 8);
         if (a > upper_limit_value) a = upper_limit_value;
         else if (a < lower_limit_value) a = lower_limit_value;
      end
      if (o[22]) a = upper_limit_value - a;
      if (o[27]) a = a + 16'h8000;
      return a;
   endfunction

   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      rchk(8'h06, 32'h0000_0000);
      apc_host_i.wr(8'h06, 32'hFFFF_FFFF);
      rchk(8'h06, 32'h0F7D_FFFF);
      apc_host_i.wr(8'h08, 32'hFFFF_FFFF);
      rchk(8'h08, 32'h00FF_FFFF);
      apc_host_i.wr(8'h07, 32'hFFFF_FFFF);
      rchk(8'h07, 32'hFFFF_FFFF);
      apc_host_i.wr(8'h09, 32'h0000_0000);
      rchk(8'h09, 32'h0000_0000);
      rchk(8'h06, 32'h0F7D_FFFF);
      // Stored origin lands in the upper bits of its working field, window in the middle, shift in the lowest.
      stored_origin_shift = 12'hABC;
      stored_reset_window = 4'h9;
      stored_numerator_shift = 5'h15;
      stored_option_bits = 12'hFFF;
      stored_numerator_a = 16'h1234;
      stored_numerator_b = 16'h8765;
      @(negedge clk);
      init_load = 1'b1;
      @(negedge clk);
      init_load = 1'b0;
      rchk(8'h06, 32'h0F7D_ABC0);
      rchk(8'h07, 32'h0090_1234);
      rchk(8'h08, 32'h0015_8765);
      apc_host_i.wr(8'h07, 32'h0000_0000);
      apc_host_i.wr(8'h08, 32'h0000_0000);
      apc_host_i.wr(8'h06, 32'h0000_0000);
      chk(32'(segment_index), 32'h0000_000A);
      for (int k = 0; k < 10; k++) begin
         apc_host_i.wr(8'h06, modes[k]);
         send(16'h3456);
         take(mdl(modes[k], 16'h3456));
      end
      // Samples offered every other cycle fill the queue until it refuses, then drain in order.
      apc_host_i.wr(8'h06, 32'h0800_0000);
      for (int k = 0; k < 4; k++) send(16'h7FF0 + 16'(k));
      @(negedge clk);
      chk(32'(in_ready), 32'h0000_0000);
      for (int k = 0; k < 4; k++) take(16'hFFF0 + 16'(k));
      // Short stroke at gain 1.5: a low sample trips the floor, a high one the ceiling.
      angle_floor_check = 16'h2000;
      angle_ceiling_check = 16'h4000;
      apc_host_i.wr(8'h06, 32'h0100_0000);
      send(16'h1000);
      take(16'h1800);
      chk(32'({fh, ch}), 32'h0000_0002);
      send(16'h3000);
      take(16'h3000);
      chk(32'({fh, ch}), 32'h0000_0001);
      // Smoothing: hold, flush on a wide step, shift and a negative numerator.
      apc_host_i.wr(8'h06, 32'h0000_0000);
      send(16'h1000);
      take(16'h1000);
      apc_host_i.wr(8'h06, 32'h0001_0000);
      send(16'h2000);
      take(16'h1000);
      chk(32'(fl), 32'h0000_0000);
      apc_host_i.wr(8'h07, 32'h0004_0000);
      send(16'h1010);
      take(16'h1010);
      chk(32'(fl), 32'h0000_0001);
      apc_host_i.wr(8'h07, 32'h0000_4000);
      apc_host_i.wr(8'h08, 32'h0001_0000);
      send(16'h1030);
      take(16'h1020);
      apc_host_i.wr(8'h08, 32'h0000_0000);
      apc_host_i.wr(8'h07, 32'h0000_C000);
      send(16'h1040);
      take(16'h1000);
      apc_host_i.wr(8'h07, 32'h0004_0000);
      send(16'h1008);
      take(16'h1000);
      chk(32'(fl), 32'h0000_0000);
      // A unit denominator takes back the last step in full, without the shift.
      smoothing_denominator_a = 16'h4000;
      apc_host_i.wr(8'h07, 32'h0000_4000);
      apc_host_i.wr(8'h08, 32'h0001_0000);
      send(16'h1040);
      take(16'h1020);
      send(16'h1020);
      take(16'h1000);
      conclude();
   end
endmodule // apc_top_tb
